// *** shared/sram_ctrl_pkg.sv ***
// Purpose: shared constants and carrier types of the sram control inputs
// Assumes: x18 organisation, two byte lanes of eight data and one parity bit
// Notes: all control pins are active low except the high-active chip enable

package sram_ctrl_pkg;

  // ************************************************************
  // organisation
  // ************************************************************
  localparam int ADDR_W = 19;
  localparam int NUM_LANES = 2;
  localparam int LANE_W = 9;
  localparam int DATA_W = NUM_LANES * LANE_W;
  localparam int CNT_W = 2;
  localparam int CNT_LSB = 0;
  localparam int SYNC_STAGES = 3;

  // ************************************************************
  // reset values and other fixed constants
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
  localparam logic [NUM_LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [NUM_LANES-1:0] LANES_ALL = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [SYNC_STAGES-1:0] SYNC_RST_HI = 3'h7;
  localparam logic [SYNC_STAGES-1:0] SYNC_RST_LO = 3'h0;

  // ************************************************************
  // carrier types
  // ************************************************************
  // synchronous control pins, all sampled on the rising edge
  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic chip_enable_primary_n;
    logic chip_enable_high_active;
    logic chip_enable_third_n;
    logic all_bytes_write_strobe_n;
    logic byte_write_qualifier_n;
    logic [NUM_LANES-1:0] byte_lane_write_select_n;
  } ctrl_pins_t;

  // one access towards the memory array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_LANES-1:0] lane_we;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } array_req_t;

  // access state
  typedef enum logic [1:0] {
    ST_DESEL = 2'b01,
    ST_ACTIVE = 2'b10
  } acc_state_t;

endpackage

// *** hw/burst_counter.sv ***
// Purpose: two-bit burst address counter with linear or interleaved order
// Assumes: load and advance come from the same clock domain
// Notes: load wins over advance in the same cycle

`timescale 1ns/1ps
`default_nettype none

module burst_counter
  import sram_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_load_val,
  input wire logic i_advance,
  input wire logic i_interleave,
  // count
  output logic [CNT_W-1:0] o_count
);

  logic [CNT_W-1:0] base_r;
  logic [CNT_W-1:0] step_r;
  logic [CNT_W-1:0] step_nxt;
  logic [CNT_W-1:0] count_r;

  assign step_nxt = CNT_W'(step_r + CNT_STEP);

  // ************************************************************
  // start value and step of the running burst
  // ************************************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      base_r <= CNT_RST;
      step_r <= CNT_RST;
    end
    else if (i_load)
    begin
      base_r <= i_load_val;
      step_r <= CNT_RST;
    end
    else if (i_advance)
      step_r <= step_nxt;
  end

  // ************************************************************
  // current address bits, wrapping in two bits
  // ************************************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      count_r <= CNT_RST;
    else if (i_load)
      count_r <= i_load_val;
    else if (i_advance)
    begin
      if (i_interleave)
        count_r <= base_r ^ step_nxt;
      else
        count_r <= CNT_W'(count_r + CNT_STEP);
    end
  end

  assign o_count = count_r;

endmodule

`default_nettype wire

// *** hw/sync_sram_control_inputs.sv ***
// Purpose: control-input logic of a synchronous flow-through sram
// Assumes: strobes, enables and writes come from logic on i_mclk;
//   output enable and order select are asynchronous pins
// Notes: array outputs and data-pin drive all come from flip-flops
//
// Operation
// - write lane when its select and qualifier low
// - all-bytes strobe low writes every lane
// - sample on rising edge, count on advance
// - selected only with all enables active
// - processor strobe ignored while primary enable high
// - processor strobe captures address, loads counter
// - processor strobe wins over controller strobe
// - advance low increments burst address
// - output enable low drives pins, else inputs
// - first read clock after deselect stays undriven
// - controller strobe captures address, loads counter
// - order pin low linear, high interleaved
// - read data from previously addressed location
// - deselected keeps data pins undriven

`timescale 1ns/1ps
`default_nettype none

module sync_sram_control_inputs
  import sram_ctrl_pkg::*;
#(
  parameter bit THREE_ENABLES = 1'b1
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // synchronous bus from the controller
  input wire ctrl_pins_t i_ctrl,
  input wire logic [ADDR_W-1:0] i_addr,
  // asynchronous and static pins
  input wire logic i_output_enable_n,
  input wire logic i_burst_order_select,
  // data pins, split three ways
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  // memory array side
  output array_req_t o_array_req,
  input wire logic [DATA_W-1:0] i_array_rdata,
  // status
  output logic o_selected
);

  // ************************************************************
  // pin synchronisers for asynchronous inputs
  // ************************************************************
  logic [SYNC_STAGES-1:0] oe_sync_r;
  logic [SYNC_STAGES-1:0] order_sync_r;
  logic oe_low_r;
  logic interleave_r;

  // three stages, change accepted once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      oe_sync_r <= SYNC_RST_HI;
      order_sync_r <= SYNC_RST_HI;
    end
    else
    begin
      oe_sync_r <= {oe_sync_r[1:0], i_output_enable_n};
      order_sync_r <= {order_sync_r[1:0], i_burst_order_select};
    end
  end

  // filtered levels; order pin is followed at all times after reset, like output enable
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      oe_low_r <= 1'b0;
      interleave_r <= 1'b1;
    end
    else
    begin
      if (oe_sync_r[1] == oe_sync_r[2])
        oe_low_r <= ~oe_sync_r[2];
      if (order_sync_r[1] == order_sync_r[2])
        interleave_r <= order_sync_r[2];
    end
  end

  // ************************************************************
  // decode of the sampled control pins
  // ************************************************************
  logic chip_sel;
  logic processor_address_strobe_take;
  logic controller_address_strobe_take;
  logic start;
  logic [NUM_LANES-1:0] lanes_wr;

  // all enables active; the third is absent on two-enable parts
  assign chip_sel = ~i_ctrl.chip_enable_primary_n &
                    i_ctrl.chip_enable_high_active &
                    (~i_ctrl.chip_enable_third_n | ~THREE_ENABLES);
  // processor strobe only counts with primary enable low
  assign processor_address_strobe_take = ~i_ctrl.processor_address_strobe_n &
                     ~i_ctrl.chip_enable_primary_n;
  // controller strobe is ignored when processor strobe is taken
  assign controller_address_strobe_take = ~i_ctrl.controller_address_strobe_n &
                     ~processor_address_strobe_take;
  assign start = processor_address_strobe_take | controller_address_strobe_take;

  // lane write decode; no strobe at all leaves a read
  always_comb
  begin
    lanes_wr = LANES_NONE;
    if (~i_ctrl.all_bytes_write_strobe_n)
      lanes_wr = LANES_ALL;
    else if (~i_ctrl.byte_write_qualifier_n)
      lanes_wr = ~i_ctrl.byte_lane_write_select_n;
  end

  // ************************************************************
  // access state
  // ************************************************************
  acc_state_t state_r;
  acc_state_t state_nxt;
  logic access;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_DESEL:
        if (start && chip_sel)
          state_nxt = ST_ACTIVE;
      ST_ACTIVE:
        if (start && !chip_sel)
          state_nxt = ST_DESEL;
      default:
        state_nxt = ST_DESEL;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_r <= ST_DESEL;
    else
      state_r <= state_nxt;
  end

  // an access happens on every edge that leaves the device selected
  assign access = (state_nxt == ST_ACTIVE);

  // ************************************************************
  // address register and burst counter
  // ************************************************************
  logic [ADDR_W-1:0] addr_r;
  logic [CNT_W-1:0] count;
  logic cnt_load;
  logic cnt_adv;

  assign cnt_load = start && chip_sel;
  // advance only inside a running burst, not on a strobe edge
  assign cnt_adv = !start && (state_r == ST_ACTIVE) &&
                   ~i_ctrl.burst_advance_n;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      addr_r <= ADDR_RST;
    else if (cnt_load)
      addr_r <= i_addr;
  end

  burst_counter u_burst_counter
  (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_load(cnt_load),
    .i_load_val(i_addr[CNT_LSB +: CNT_W]),
    .i_advance(cnt_adv),
    .i_interleave(interleave_r),
    .o_count(count)
  );

  // ************************************************************
  // request towards the array
  // ************************************************************
  logic [NUM_LANES-1:0] lane_we_r;
  logic rd_r;
  logic [DATA_W-1:0] wdata_r;

  // write lanes and read strobe for the access of this edge
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lane_we_r <= LANES_NONE;
      rd_r <= 1'b0;
    end
    else
    begin
      lane_we_r <= access ? lanes_wr : LANES_NONE;
      rd_r <= access && (lanes_wr == LANES_NONE);
    end
  end

  // data pins act as inputs into the write data register
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      wdata_r <= DATA_RST;
    else
      wdata_r <= i_dq;
  end

  assign o_array_req.addr = {addr_r[ADDR_W-1:CNT_W], count};
  assign o_array_req.lane_we = lane_we_r;
  assign o_array_req.rd = rd_r;
  assign o_array_req.wdata = wdata_r;

  // ************************************************************
  // read data and data-pin direction
  // ************************************************************
  logic [DATA_W-1:0] dq_r;
  logic dq_oe_n_r;
  logic first_r;
  logic selected_r;

  // set on the edge that opens a burst from the deselected state
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      first_r <= 1'b0;
    else
      first_r <= (state_r == ST_DESEL) && access;
  end

  // data of the location addressed on the previous edge
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      dq_r <= DATA_RST;
    else
      dq_r <= i_array_rdata;
  end

  // drive only for a selected read, output enable low, not masked
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      dq_oe_n_r <= 1'b1;
    else
      dq_oe_n_r <= ~(rd_r && access && oe_low_r &&
                     !first_r);
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      selected_r <= 1'b0;
    else
      selected_r <= access;
  end

  assign o_dq = dq_r;
  assign o_dq_oe_n = dq_oe_n_r;
  assign o_selected = selected_r;

endmodule

`default_nettype wire

// *** tb/sram_array_model.sv ***
// Purpose: memory array behind the sram control block
// Assumes: sixteen words, indexed by the low address bits
// Notes: words start at zero so partial lane writes are predictable
`timescale 1ns/1ps
`default_nettype none
module sram_array_model
  import sram_ctrl_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // request and read data
  input wire array_req_t i_req,
  output logic [DATA_W-1:0] o_rdata
);
  logic [DATA_W-1:0] mem_r [16];
  // ************************************************************
  // storage
  // ************************************************************
  initial
  begin
    foreach (mem_r[k])
      mem_r[k] = DATA_RST;
  end
  // each enabled lane lands on the clock after the request
  always @(posedge i_mclk)
  begin
    if (i_req.lane_we[0])
      mem_r[i_req.addr[3:0]][LANE_W-1:0] <= i_req.wdata[LANE_W-1:0];
    if (i_req.lane_we[1])
      mem_r[i_req.addr[3:0]][DATA_W-1:LANE_W] <= i_req.wdata[DATA_W-1:LANE_W];
  end
  // flow-through read of the requested word
  assign o_rdata = mem_r[i_req.addr[3:0]];
endmodule
`default_nettype wire

// *** tb/sync_sram_control_inputs_assertions.sv ***
// Purpose: port-level checks of the sram control inputs
// Assumes: one clock domain, asynchronous active-high reset
// Notes: write controls of edge n show on o_array_req.lane_we after edge n
`timescale 1ns/1ps
`default_nettype none
module sync_sram_control_inputs_assertions
  import sram_ctrl_pkg::*;
#(
  parameter bit THREE_ENABLES = 1'b1
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // watched ports
  input wire ctrl_pins_t i_ctrl,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_output_enable_n,
  input wire logic i_burst_order_select,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe_n,
  input wire array_req_t o_array_req,
  input wire logic [DATA_W-1:0] i_array_rdata,
  input wire logic o_selected
);
  // ************************************************************
  // decoded pins
  // ************************************************************
  wire logic ps_on = !i_ctrl.processor_address_strobe_n;
  wire logic cs_on = !i_ctrl.controller_address_strobe_n;
  wire logic ce1_off = i_ctrl.chip_enable_primary_n;
  wire logic en_all = !ce1_off && i_ctrl.chip_enable_high_active
    && (!i_ctrl.chip_enable_third_n || !THREE_ENABLES);
  wire logic take_on = (ps_on && !ce1_off) || cs_on;
  wire logic gw_on = !i_ctrl.all_bytes_write_strobe_n;
  wire logic bwe_on = !i_ctrl.byte_write_qualifier_n;
  wire logic adv_on = !i_ctrl.burst_advance_n;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  a_all_lanes:
    assert property (gw_on |=> !o_selected || o_array_req.lane_we == LANES_ALL)
      else $error("all-bytes write missed a lane");
  a_lane_pick:
    assert property (!gw_on && bwe_on |=> !o_selected
      || o_array_req.lane_we == ~$past(i_ctrl.byte_lane_write_select_n))
      else $error("lane write enables differ from selects");
  a_plain_read:
    assert property (!gw_on && !bwe_on |=> !o_selected
      || (o_array_req.rd && o_array_req.lane_we == LANES_NONE))
      else $error("access without write strobes was not a read");
  a_proc_capture:
    assert property (ps_on && en_all |=> o_selected
      && o_array_req.addr == $past(i_addr))
      else $error("processor strobe did not capture address");
  a_ctrl_capture:
    assert property (!ps_on && cs_on && en_all |=> o_selected
      && o_array_req.addr == $past(i_addr))
      else $error("controller strobe did not capture address");
  a_strobe_deselect:
    assert property (take_on && !en_all |=> !o_selected)
      else $error("strobe with inactive enables did not deselect");
  a_proc_ignored:
    assert property (ps_on && ce1_off && !cs_on && !o_selected |=> !o_selected)
      else $error("processor strobe honoured with primary enable high");
  a_linear_step:
    assert property (o_selected && !take_on && adv_on && !i_burst_order_select
      |=> o_array_req.addr[1:0] == $past(o_array_req.addr[1:0]) + 2'h1)
      else $error("linear burst step wrong");
  a_burst_hold:
    assert property (o_selected && !take_on && !adv_on
      |=> $stable(o_array_req.addr))
      else $error("burst address moved without advance");
  a_first_masked:
    assert property (!o_selected ##1 o_selected |=> o_dq_oe_n)
      else $error("data pins driven on first clock after deselect");
  a_desel_quiet:
    assert property (!o_selected |=> o_dq_oe_n)
      else $error("data pins driven while deselected");
  a_write_quiet:
    assert property (o_selected && o_array_req.lane_we != LANES_NONE
      |=> o_dq_oe_n)
      else $error("data pins driven during a write");
  a_oe_high:
    assert property (i_output_enable_n [*5] |=> o_dq_oe_n)
      else $error("data pins driven with output enable high");
  a_read_data:
    assert property (o_selected |=> o_dq == $past(i_array_rdata))
      else $error("read data not from previous address");
endmodule
bind sync_sram_control_inputs sync_sram_control_inputs_assertions
  #(.THREE_ENABLES(THREE_ENABLES)) u_chk (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_ctrl(i_ctrl), .i_addr(i_addr),
  .i_output_enable_n(i_output_enable_n),
  .i_burst_order_select(i_burst_order_select), .i_dq(i_dq), .o_dq(o_dq),
  .o_dq_oe_n(o_dq_oe_n), .o_array_req(o_array_req),
  .i_array_rdata(i_array_rdata), .o_selected(o_selected));
`default_nettype wire

// *** tb/sync_sram_control_inputs_bench.sv ***
// Purpose: directed bench of the sram control inputs
// Assumes: pin vectors ordered as the control struct, idle vector with all enables active
// Notes: outputs are read 1 ns after the edge that produced them
`timescale 1ns/1ps
`default_nettype none
module sync_sram_control_inputs_bench
  import sram_ctrl_pkg::*;
;
  logic clk, rst, oe_n, order, q_oe_n, sel;
  ctrl_pins_t ctrl;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq, q, rdata;
  array_req_t req;
  int num_errors = 0;
  int num_checks = 0;
  logic [DATA_W-1:0] wd [4] = '{18'h2A5A5, 18'h15A5A, 18'h3C3C3, 18'h0F0F0};
  logic [DATA_W-1:0] md [4] = '{18'h2A5A5, 18'h15A5A, 18'h001C3, 18'h0F000};
  sync_sram_control_inputs u_dut (.i_mclk(clk), .i_sys_rst(rst),
    .i_ctrl(ctrl), .i_addr(addr), .i_output_enable_n(oe_n),
    .i_burst_order_select(order), .i_dq(dq), .o_dq(q), .o_dq_oe_n(q_oe_n),
    .o_array_req(req), .i_array_rdata(rdata), .o_selected(sel));
  sram_array_model u_mem (.i_mclk(clk), .i_req(req), .o_rdata(rdata));
  // ************************************************************
  // helpers and scenarios
  // ************************************************************
  task automatic check(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic step(input logic [9:0] c, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(negedge clk);
    ctrl = c;
    addr = a;
    dq = d;
    @(posedge clk);
    #1;
  endtask
  task automatic sc(input logic [9:0] c, input logic [ADDR_W-1:0] a,
    input logic e);
    step(c, a, 18'h00000);
    check("selected", e, sel);
  endtask
  task automatic t_writes;
    step(10'h2A7, 19'h00014, wd[0]);
    check("all lanes", 2'h3, req.lane_we);
    check("wdata", wd[0], req.wdata);
    check("ctrl addr", 19'h00014, req.addr);
    step(10'h327, 19'h00000, wd[1]);
    check("advanced addr", 19'h00015, req.addr);
    step(10'h2AA, 19'h00016, wd[2]);
    check("lane a", 2'h1, req.lane_we);
    step(10'h2A9, 19'h00017, wd[3]);
    check("lane b", 2'h2, req.lane_we);
    step(10'h2AC, 19'h00017, 18'h3FFFF);
    check("read flag", 1'h1, req.rd);
    check("no lanes", 2'h0, req.lane_we);
    $display("done writes");
  endtask
  task automatic t_strobes;
    sc(10'h0EF, 19'h00015, 1'h0);
    sc(10'h1EF, 19'h00015, 1'h0);
    sc(10'h0AF, 19'h00014, 1'h1);
    check("both strobes", 19'h00014, req.addr);
    sc(10'h2BF, 19'h00015, 1'h0);
    sc(10'h2AF, 19'h00016, 1'h1);
    sc(10'h28F, 19'h00016, 1'h0);
    $display("done strobes");
  endtask
  task automatic t_readback;
    step(10'h3AF, 19'h00000, 18'h00000);
    check("idle undriven", 1'h1, q_oe_n);
    step(10'h1AF, 19'h00014, 18'h00000);
    check("proc addr", 19'h00014, req.addr);
    check("first clock", 1'h1, q_oe_n);
    for (int k = 0; k < 4; k++)
    begin
      step(k < 3 ? 10'h32F : 10'h3AF, 19'h00000, 18'h00000);
      check("read data", md[k], q);
      check("burst addr", 19'h00015 + (k < 3 ? k : 2), req.addr);
      if (k > 0)
        check("driving", 1'h0, q_oe_n);
      else
        check("first data clock", 1'h1, q_oe_n);
    end
    $display("done readback");
  endtask
  task automatic t_order(input logic ord, oe_v, input logic [1:0] st,
    input logic [7:0] seq);
    step(10'h28F, 19'h00000, 18'h00000);
    @(negedge clk);
    order = ord;
    oe_n = oe_v;
    repeat (4) step(10'h3AF, 19'h00000, 18'h00000);
    for (int k = 0; k < 4; k++)
    begin
      step(k == 0 ? 10'h1AF : 10'h32F, {17'h00005, st}, 18'h00000);
      check("order addr", {17'h00005, seq[7-2*k -: 2]}, req.addr);
    end
    if (oe_v)
      check("oe high", 1'h1, q_oe_n);
    $display("done order");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #20000;
    num_errors++;
    stop_test;
  end
  initial
  begin
    rst = 1'b1;
    ctrl = 10'h3AF;
    addr = 19'h00000;
    dq = 18'h00000;
    oe_n = 1'b0;
    order = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("reset oe", 1'h1, q_oe_n);
    check("reset sel", 1'h0, sel);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) step(10'h3AF, 19'h00000, 18'h00000);
    t_writes;
    t_strobes;
    t_readback;
    t_order(1'b0, 1'b0, 2'h2, 8'hB1);
    t_order(1'b1, 1'b1, 2'h1, 8'h4E);
    stop_test;
  end
endmodule
`default_nettype wire
